// [hdl/port1_gpio_pin_mux.sv]
// Eight-pin I/O port with per-pin alternate functions, Avalon-MM register slave
// and a level interrupt. Assumes pins and power mode are synchronous to clk_sys.
//
// Overview of operation
// [RQ1] Pin six select bit: 0 gives general I/O, 1 gives active-low capture input.
// [RQ2] Pins five to zero select bits: 0 general I/O, 1 external interrupt input.
// [RQ3] Each direction bit: 1 makes its pin output, 0 input.
// [RQ4] Direction and latch govern a pin only while it is general I/O.
// [RQ5] Direction register is write-only; reading it returns all ones.
// [RQ6] Reset clears direction, data latch and pull-up select to zero.
// [RQ7] Output pins read back the latched value, not the pin.
// [RQ8] Input pins read back the sampled pin level.
// [RQ9] Pull-up acts only on input pins; forced off on outputs.
// [RQ10] Pull-up select bit: 0 no pull-up, 1 pull-up.
// [RQ11] Pin seven select 1 drives divided clock regardless of direction.
// [RQ12] Capture input ignores direction; noise-cancel bit bypasses or inserts the filter.
// [RQ13] Interrupt pins ignore direction while selected.
// [RQ14] Interrupt inputs detect rising or falling; input zero may detect both.
// [RQ15] Interrupt inputs one, two feed timer events; input three feeds timer capture.
// [RQ16] Pins float in reset, standby, watch; run in active, subactive; hold in sleeps.
// [RQ17] Software masks interrupts and clears stale flags when changing pin functions.
// [RQ18] Writes land on the bus cycle; pins follow from the next clock.
`timescale 1ns/1ps
module port1_gpio_pin_mux
   import port1_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [port1_pkg::BUS_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [port1_pkg::BUS_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [port1_pkg::BUS_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [port1_pkg::PIN_W-1:0] pin_in,
   output logic [port1_pkg::PIN_W-1:0] pin_out,
   output logic [port1_pkg::PIN_W-1:0] pin_oe_n,
   output logic [port1_pkg::PIN_W-1:0] pullup_en,
   input wire logic divided_clock_output,
   input wire port1_pkg::pmode_t power_mode,
   output logic capture_input_n,
   output logic [1:0] timer_event_n,
   output logic timer_capture_n,
   output logic irq
);
   import port1_pkg::*;

   logic [7:0] func_sel_r;
   logic [7:0] dir_r;
   logic [7:0] latch_r;
   logic [7:0] pullup_sel_r;
   logic [6:0] edge_sel_r;
   logic nc_en_r;
   logic [6:0] irq_stat_r;
   logic [6:0] irq_en_r;
   logic ack_r;
   logic [BUS_DATA_W-1:0] readdata_r;
   logic [7:0] pin_out_r;
   logic [7:0] pin_oe_n_r;
   logic [7:0] pullup_r;
   logic [2:0] nc_div_r;
   logic [NC_TAPS-1:0] nc_samp_r;
   logic nc_filt_r;
   logic capt_r;
   logic [5:0] irq_prev_r;
   logic [1:0] tmr_evt_r;
   logic tmr_capt_r;

   logic [15:0] idx;
   logic lane_ok;
   logic wr_go;
   logic [7:0] wbyte;
   logic [BUS_DATA_W-1:0] rd_nxt;
   logic [7:0] port_rd;
   logic [7:0] drive;
   logic [7:0] pin_out_nxt;
   logic [7:0] pullup_nxt;
   logic nc_tick;
   logic capt_level;
   logic [5:0] irq_rise;
   logic [5:0] irq_fall;
   logic [6:0] evt;
   logic [6:0] clr_mask;

   // Bus slave: one wait cycle, then the access completes
   assign idx = avs_address[BUS_ADDR_W-1:2];
   assign lane_ok = (avs_address[1:0] == WORD_LANE);
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign wr_go = avs_write & ack_r & lane_ok & avs_byteenable[0];
   assign wbyte = avs_writedata[7:0];
   assign avs_readdata = readdata_r;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         ack_r <= 1'b0;
      else
         ack_r <= (avs_read | avs_write) & ~ack_r;
   end

   // Per-bit port readback: latch for outputs, pin for inputs
   assign port_rd = (dir_r & latch_r) | (~dir_r & pin_in); // [RQ7] [RQ8]

   always_comb
   begin
      rd_nxt = READ_ZERO;
      if (!lane_ok)
         rd_nxt = READ_ZERO;
      else if (idx == IDX_FUNC_SEL)
         rd_nxt[7:0] = func_sel_r;
      else if (idx == IDX_DIR)
         rd_nxt[7:0] = DIR_READBACK; // [RQ5]
      else if (idx == IDX_LATCH)
         rd_nxt[7:0] = port_rd;
      else if (idx == IDX_PULLUP)
         rd_nxt[7:0] = pullup_sel_r;
      else if (idx == IDX_EDGE_SEL)
         rd_nxt[6:0] = edge_sel_r;
      else if (idx == IDX_NC_CTRL)
         rd_nxt[NC_EN_BIT] = nc_en_r;
      else if (idx == IDX_IRQ_STAT)
         rd_nxt[6:0] = irq_stat_r;
      else if (idx == IDX_IRQ_EN)
         rd_nxt[6:0] = irq_en_r;
      else
         rd_nxt = READ_ZERO;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         readdata_r <= READ_ZERO;
      else if (avs_read & ~ack_r)
         readdata_r <= rd_nxt;
   end

   // Configuration registers, written at the completing bus edge
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         func_sel_r <= RST_FUNC_SEL;
         dir_r <= RST_DIR; // [RQ6]
         latch_r <= RST_LATCH; // [RQ6]
         pullup_sel_r <= RST_PULLUP; // [RQ6]
         edge_sel_r <= RST_EDGE_SEL;
         nc_en_r <= 1'b0;
         irq_en_r <= RST_EVENTS;
      end
      else if (wr_go)
      begin
         if (idx == IDX_FUNC_SEL)
            func_sel_r <= wbyte; // [RQ18]
         else if (idx == IDX_DIR)
            dir_r <= wbyte; // [RQ3] [RQ18]
         else if (idx == IDX_LATCH)
            latch_r <= wbyte;
         else if (idx == IDX_PULLUP)
            pullup_sel_r <= wbyte;
         else if (idx == IDX_EDGE_SEL)
            edge_sel_r <= wbyte[6:0];
         else if (idx == IDX_NC_CTRL)
            nc_en_r <= wbyte[NC_EN_BIT];
         else if (idx == IDX_IRQ_EN)
            irq_en_r <= wbyte[6:0];
      end
   end

   // Pin drive: alternate functions override direction and latch
   always_comb
   begin
      drive = dir_r & ~func_sel_r; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ13]
      pin_out_nxt = latch_r;
      if (func_sel_r[PIN_CLKOUT])
      begin
         drive[PIN_CLKOUT] = 1'b1; // [RQ11]
         pin_out_nxt[PIN_CLKOUT] = divided_clock_output; // [RQ11]
      end
      pullup_nxt = pullup_sel_r & ~drive; // [RQ9] [RQ10]
   end

   // Hold modes freeze the pins; floating modes release them
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pin_out_r <= NONE_DRIVEN;
         pin_oe_n_r <= ALL_FLOAT_N; // [RQ16]
         pullup_r <= NONE_DRIVEN;
      end
      else
      begin
         case (power_mode)
            PM_ACTIVE, PM_SUBACTIVE:
            begin
               pin_out_r <= pin_out_nxt; // [RQ18]
               pin_oe_n_r <= ~drive;
               pullup_r <= pullup_nxt;
            end
            PM_SLEEP, PM_SUBSLEEP:
            begin
               pin_out_r <= pin_out_r; // [RQ16]
               pin_oe_n_r <= pin_oe_n_r;
               pullup_r <= pullup_r;
            end
            default:
            begin
               pin_out_r <= NONE_DRIVEN;
               pin_oe_n_r <= ALL_FLOAT_N; // [RQ16]
               pullup_r <= NONE_DRIVEN;
            end
         endcase
      end
   end

   assign pin_out = pin_out_r;
   assign pin_oe_n = pin_oe_n_r;
   assign pullup_en = pullup_r;

   // Noise canceller: level changes only after three equal samples
   assign nc_tick = (nc_div_r == NC_DIV - 3'h1);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         nc_div_r <= 3'h0;
         nc_samp_r <= '1;
         nc_filt_r <= 1'b1;
      end
      else
      begin
         nc_div_r <= nc_tick ? 3'h0 : nc_div_r + 3'h1;
         if (nc_tick)
            nc_samp_r <= {nc_samp_r[NC_TAPS-2:0], pin_in[PIN_CAPT]};
         if (&nc_samp_r)
            nc_filt_r <= 1'b1;
         else if (~|nc_samp_r)
            nc_filt_r <= 1'b0;
      end
   end

   assign capt_level = nc_en_r ? nc_filt_r : pin_in[PIN_CAPT]; // [RQ12]

   // Edge detection for capture and interrupt pins
   assign irq_rise = pin_in[5:0] & ~irq_prev_r;
   assign irq_fall = ~pin_in[5:0] & irq_prev_r;

   always_comb
   begin
      evt = RST_EVENTS;
      for (int i = 0; i < IRQ_N; i++)
         evt[i] = func_sel_r[i] & (edge_sel_r[i] ? irq_rise[i] : irq_fall[i]); // [RQ14]
      if (edge_sel_r[IRQ_BOTH_BIT])
         evt[0] = func_sel_r[0] & (irq_rise[0] | irq_fall[0]); // [RQ14]
      evt[EVT_CAPT] = func_sel_r[PIN_CAPT] & capt_r & ~capt_level; // [RQ1] [RQ12]
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         irq_prev_r <= '1;
         capt_r <= 1'b1;
         tmr_evt_r <= 2'h3;
         tmr_capt_r <= 1'b1;
      end
      else
      begin
         irq_prev_r <= pin_in[5:0];
         capt_r <= capt_level;
         // Deselected pins present an idle high level downstream
         tmr_evt_r <= pin_in[IRQ_TMR_EVT_LO +: 2] | ~func_sel_r[IRQ_TMR_EVT_LO +: 2]; // [RQ15]
         tmr_capt_r <= pin_in[IRQ_TMR_CAPT] | ~func_sel_r[IRQ_TMR_CAPT]; // [RQ15]
      end
   end

   assign capture_input_n = capt_r;
   assign timer_event_n = tmr_evt_r;
   assign timer_capture_n = tmr_capt_r;

   // Sticky status; a new event beats a clear in the same cycle
   assign clr_mask = (wr_go && idx == IDX_IRQ_CLR) ? wbyte[6:0] : RST_EVENTS;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         irq_stat_r <= RST_EVENTS;
      else
         irq_stat_r <= (irq_stat_r & ~clr_mask) | evt; // [RQ17]
   end

   assign irq = |(irq_stat_r & irq_en_r);

   // Checks
   a_reset_clears: assert property (@(posedge clk_sys) rst |=> (dir_r == RST_DIR && latch_r == RST_LATCH
      && pullup_sel_r == RST_PULLUP && pin_oe_n == ALL_FLOAT_N)) // [RQ6]
      else $error("reset values wrong");
   a_dir_reads_ones: assert property (@(posedge clk_sys) disable iff (rst)
      (avs_read && !avs_waitrequest && avs_address == {IDX_DIR, WORD_LANE}) |-> avs_readdata[7:0] == DIR_READBACK) // [RQ5]
      else $error("direction readback not all ones");
   a_port_readback: assert property (@(posedge clk_sys) disable iff (rst)
      (avs_read && !avs_waitrequest && avs_address == {IDX_LATCH, WORD_LANE})
      |-> avs_readdata[7:0] == ((dir_r & latch_r) | (~dir_r & $past(pin_in)))) // [RQ7]
      else $error("port readback mismatch");
   a_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
      (wr_go && idx == IDX_FUNC_SEL) |=> func_sel_r == $past(wbyte)) // [RQ18]
      else $error("select write lost");
   a_gp_drive: assert property (@(posedge clk_sys) disable iff (rst)
      (power_mode == PM_ACTIVE && func_sel_r == RST_FUNC_SEL) |=> (pin_oe_n == ~$past(dir_r)
      && pin_out == $past(latch_r))) // [RQ3]
      else $error("general I/O drive wrong");
   a_alt_inputs_float: assert property (@(posedge clk_sys) disable iff (rst)
      (power_mode == PM_ACTIVE) |=> ((~pin_oe_n[6:0] & $past(func_sel_r[6:0])) == 7'h00)) // [RQ4]
      else $error("alternate input pin driven");
   a_clkout_drive: assert property (@(posedge clk_sys) disable iff (rst)
      ((power_mode == PM_ACTIVE || power_mode == PM_SUBACTIVE) && func_sel_r[PIN_CLKOUT]) |=> (!pin_oe_n[PIN_CLKOUT]
      && pin_out[PIN_CLKOUT] == $past(divided_clock_output))) // [RQ11]
      else $error("clock output not driven");
   a_pullup_inputs: assert property (@(posedge clk_sys) disable iff (rst)
      (pullup_en & ~pin_oe_n) == NONE_DRIVEN) // [RQ9]
      else $error("pull-up on driven pin");
   a_float_standby: assert property (@(posedge clk_sys) disable iff (rst)
      (power_mode == PM_STANDBY || power_mode == PM_WATCH) |=> (pin_oe_n == ALL_FLOAT_N
      && pullup_en == NONE_DRIVEN)) // [RQ16]
      else $error("pins not floating");
   a_hold_sleep: assert property (@(posedge clk_sys) disable iff (rst)
      (power_mode == PM_SLEEP || power_mode == PM_SUBSLEEP) |=> ($stable(pin_out) && $stable(pin_oe_n))) // [RQ16]
      else $error("pins changed while held");
   a_irq0_both: assert property (@(posedge clk_sys) disable iff (rst)
      (func_sel_r[0] && edge_sel_r[IRQ_BOTH_BIT] && pin_in[0] != irq_prev_r[0]) |=> irq_stat_r[0]) // [RQ14]
      else $error("both-edge event missed");
   a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (rst)
      (|(evt & clr_mask)) |=> ((irq_stat_r & $past(evt)) == $past(evt))) // [RQ14]
      else $error("event lost to clear");
   a_irq_follows: assert property (@(posedge clk_sys) disable iff (rst)
      (evt[1] && irq_en_r[1]) |=> irq) // [RQ2]
      else $error("enabled event gave no interrupt");
   a_timer_route: assert property (@(posedge clk_sys) disable iff (rst)
      (func_sel_r[IRQ_TMR_CAPT] && !pin_in[IRQ_TMR_CAPT]) |=> !timer_capture_n) // [RQ15]
      else $error("timer capture not routed");

   c_clkout: cover property (@(posedge clk_sys) func_sel_r[PIN_CLKOUT] && !pin_oe_n[PIN_CLKOUT]);
   c_capture_filtered: cover property (@(posedge clk_sys) nc_en_r && evt[EVT_CAPT]);
   c_irq0_both: cover property (@(posedge clk_sys) edge_sel_r[IRQ_BOTH_BIT] && evt[0] && irq_rise[0] == 1'b0);
   c_irq_out: cover property (@(posedge clk_sys) irq);
endmodule

// [hdl/port1_pkg.sv]
// Constants, register map and types for the eight-pin multiplexed I/O port.
// Assumes a 25 MHz system clock and byte-wide registers on a 32-bit bus.
package port1_pkg;
   localparam int PIN_W = 8;
   localparam int BUS_ADDR_W = 18;
   localparam int BUS_DATA_W = 32;
   localparam int CLK_PERIOD_NS = 40;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_FUNC_SEL = 16'hffce;
   localparam logic [15:0] IDX_DIR = 16'hffd1;
   localparam logic [15:0] IDX_LATCH = 16'hffc1;
   localparam logic [15:0] IDX_PULLUP = 16'hffe1;
   localparam logic [15:0] IDX_EDGE_SEL = 16'hff00;
   localparam logic [15:0] IDX_NC_CTRL = 16'hff01;
   localparam logic [15:0] IDX_IRQ_STAT = 16'hff02;
   localparam logic [15:0] IDX_IRQ_EN = 16'hff03;
   localparam logic [15:0] IDX_IRQ_CLR = 16'hff04;
   localparam logic [1:0] WORD_LANE = 2'h0;

   localparam logic [7:0] RST_FUNC_SEL = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_PULLUP = 8'h00;
   localparam logic [6:0] RST_EDGE_SEL = 7'h00;
   localparam logic [6:0] RST_EVENTS = 7'h00;
   localparam logic [7:0] DIR_READBACK = 8'hff;
   localparam logic [7:0] ALL_FLOAT_N = 8'hff;
   localparam logic [7:0] NONE_DRIVEN = 8'h00;
   localparam logic [BUS_DATA_W-1:0] READ_ZERO = 32'h00000000;

   // Pin positions and field layout
   localparam int PIN_CLKOUT = 7;
   localparam int PIN_CAPT = 6;
   localparam int IRQ_N = 6;
   localparam int IRQ_BOTH_BIT = 6;
   localparam int EVT_CAPT = 6;
   localparam int NC_EN_BIT = 0;
   localparam int IRQ_TMR_EVT_LO = 1;
   localparam int IRQ_TMR_CAPT = 3;

   // Noise canceller: three agreeing samples taken every 160 ns
   localparam int NC_SAMPLE_NS = 160;
   localparam int NC_DIV_INT = (NC_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] NC_DIV = NC_DIV_INT[2:0];
   localparam int NC_TAPS = 3;

   typedef enum logic [2:0]
   {
      PM_ACTIVE = 3'b000,
      PM_SLEEP = 3'b001,
      PM_STANDBY = 3'b010,
      PM_WATCH = 3'b011,
      PM_SUBACTIVE = 3'b100,
      PM_SUBSLEEP = 3'b101
   } pmode_t;
endpackage

// [testbench/board_model.sv]
// Board model: outside world on the eight port pins.
// Assumes the port samples pin levels on clk_sys; an external driver overpowers the port.
`timescale 1ns/1ps
module board_model
(
   input wire logic clk_sys,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] pullup_en,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pin_in
);
   logic float_r = 1'b0;

   // Undriven lines alternate so a stale level never passes for a match
   always_ff @(posedge clk_sys)
   begin
      float_r <= ~float_r;
   end

   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (ext_en[i])
            pin_in[i] = ext_val[i];
         else if (!pin_oe_n[i])
            pin_in[i] = pin_out[i];
         else if (pullup_en[i])
            pin_in[i] = 1'b1;
         else
            pin_in[i] = float_r;
      end
   end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the multiplexed port: registers, pin mux, events, power modes.
// Assumes the board model on the pins and an Avalon-MM master driven from here.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
   import port1_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [BUS_ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [BUS_DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [BUS_DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] pin_in, pin_out, pin_oe_n, pullup_en, q;
   logic [7:0] ext_en = 8'hff;
   logic [7:0] ext_val = 8'h3c;
   logic tmr_clk = 1'b0;
   pmode_t power_mode = PM_ACTIVE;
   logic capture_input_n, timer_capture_n, irq, g;
   logic [1:0] timer_event_n;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #20 clk_sys = ~clk_sys;

   always @(posedge clk_sys)
   begin
      tmr_clk <= ~tmr_clk;
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         stop_test();
      end
   end

   port1_gpio_pin_mux u_port1_gpio_pin_mux (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
      .divided_clock_output(tmr_clk), .power_mode(power_mode), .capture_input_n(capture_input_n),
      .timer_event_n(timer_event_n), .timer_capture_n(timer_capture_n), .irq(irq));
   board_model u_board_model (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Waitrequest is sampled at each rising edge; the transfer ends at the first edge that sees it low
   task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= {idx, 2'h0};
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= {24'h000000, d};
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk_sys);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rd(input logic [15:0] idx, input logic [7:0] e, input string n);
      bus(1'b0, idx, 8'h00);
      `CHK(n, e, q)
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   task automatic pins(input logic [7:0] v);
      @(posedge clk_sys);
      ext_val <= v;
   endtask

   task automatic t_reset();
      `CHK("oe_n", 8'hff, pin_oe_n)
      `CHK("pu_en", 8'h00, pullup_en)
      rd(IDX_FUNC_SEL, 8'h00, "func");
      rd(IDX_DIR, 8'hff, "dir");
      rd(IDX_PULLUP, 8'h00, "pu_sel");
      rd(IDX_LATCH, 8'h3c, "port_in");
      wr(IDX_DIR, 8'hff);
      tick(2);
      `CHK("latch", 8'h00, pin_out)
   endtask

   task automatic t_io();
      wr(IDX_LATCH, 8'ha5);
      tick(2);
      `CHK("oe_n", 8'h00, pin_oe_n)
      `CHK("out", 8'ha5, pin_out)
      rd(IDX_LATCH, 8'ha5, "port_out");
      wr(IDX_PULLUP, 8'hff);
      wr(IDX_DIR, 8'h0f);
      tick(2);
      `CHK("pu_en", 8'hf0, pullup_en)
      `CHK("oe_n", 8'hf0, pin_oe_n)
      rd(IDX_LATCH, 8'h35, "port_mix");
      rd(IDX_DIR, 8'hff, "dir");
      @(posedge clk_sys);
      ext_en <= 8'h0f;
      rd(IDX_LATCH, 8'hf5, "pulled");
      @(posedge clk_sys);
      ext_en <= 8'hff;
      avs_byteenable <= 4'h0;
      wr(IDX_LATCH, 8'h00);
      avs_byteenable <= 4'hf;
      rd(IDX_LATCH, 8'h35, "no_lane");
      rd(16'h0000, 8'h00, "unmapped");
   endtask

   task automatic t_func();
      wr(IDX_DIR, 8'hff);
      wr(IDX_FUNC_SEL, 8'hff);
      tick(2);
      `CHK("oe_n", 8'h7f, pin_oe_n)
      `CHK("clk0", ~tmr_clk, pin_out[7])
      tick(1);
      `CHK("clk1", ~tmr_clk, pin_out[7])
      rd(IDX_FUNC_SEL, 8'hff, "func");
      wr(IDX_FUNC_SEL, 8'h00);
      wr(IDX_DIR, 8'h00);
      tick(2);
      `CHK("oe_n", 8'hff, pin_oe_n)
   endtask

   task automatic t_irq();
      wr(IDX_IRQ_EN, 8'h00);
      wr(IDX_DIR, 8'hff);
      wr(IDX_FUNC_SEL, 8'h3f);
      wr(IDX_EDGE_SEL, 8'h3f);
      pins(8'h00);
      tick(3);
      wr(IDX_IRQ_CLR, 8'h7f);
      wr(IDX_IRQ_EN, 8'h3f);
      tick(1);
      `CHK("oe_n", 8'h3f, pin_oe_n)
      `CHK("irq", 1'b0, irq)
      pins(8'h3f);
      tick(3);
      `CHK("irq", 1'b1, irq)
      pins(8'h35);
      tick(3);
      `CHK("evt", 2'b10, timer_event_n)
      `CHK("capt", 1'b0, timer_capture_n)
      rd(IDX_IRQ_STAT, 8'h3f, "rise");
      wr(IDX_IRQ_EN, 8'h00);
      tick(1);
      `CHK("masked", 1'b0, irq)
      wr(IDX_IRQ_CLR, 8'h3f);
      wr(IDX_EDGE_SEL, 8'h00);
      pins(8'h31);
      tick(3);
      rd(IDX_IRQ_STAT, 8'h04, "fall");
      wr(IDX_EDGE_SEL, 8'h40);
      wr(IDX_IRQ_CLR, 8'h7f);
      pins(8'h30);
      tick(3);
      rd(IDX_IRQ_STAT, 8'h01, "both_f");
      wr(IDX_IRQ_CLR, 8'h01);
      pins(8'h31);
      tick(3);
      rd(IDX_IRQ_STAT, 8'h01, "both_r");
      // Falling edge on input zero lands on the same edge as its clear
      fork
         wr(IDX_IRQ_CLR, 8'h01);
         begin
            @(posedge clk_sys);
            pins(8'h30);
         end
      join
      rd(IDX_IRQ_STAT, 8'h01, "set_wins");
   endtask

   task automatic t_capture();
      wr(IDX_FUNC_SEL, 8'h40);
      wr(IDX_NC_CTRL, 8'h00);
      pins(8'h71);
      tick(3);
      wr(IDX_IRQ_CLR, 8'h7f);
      pins(8'h31);
      tick(3);
      `CHK("capt", 1'b0, capture_input_n)
      rd(IDX_IRQ_STAT, 8'h40, "capt_evt");
      wr(IDX_NC_CTRL, 8'h01);
      pins(8'h71);
      tick(20);
      `CHK("nc_hi", 1'b1, capture_input_n)
      pins(8'h31);
      pins(8'h71);
      g = 1'b0;
      repeat (20)
      begin
         @(posedge clk_sys);
         g |= ~capture_input_n;
      end
      `CHK("glitch", 1'b0, g)
      pins(8'h31);
      tick(20);
      `CHK("nc_lo", 1'b0, capture_input_n)
   endtask

   task automatic mode(input pmode_t m);
      @(posedge clk_sys);
      power_mode <= m;
      tick(2);
   endtask

   task automatic t_power();
      wr(IDX_FUNC_SEL, 8'h00);
      wr(IDX_LATCH, 8'h55);
      mode(PM_SLEEP);
      wr(IDX_LATCH, 8'haa);
      tick(2);
      `CHK("sleep", 8'h55, pin_out)
      `CHK("sleep_oe", 8'h00, pin_oe_n)
      mode(PM_STANDBY);
      `CHK("standby", 8'hff, pin_oe_n)
      mode(PM_WATCH);
      `CHK("watch", 8'hff, pin_oe_n)
      mode(PM_SUBACTIVE);
      `CHK("subact", 8'haa, pin_out)
      `CHK("oe_n", 8'h00, pin_oe_n)
      mode(PM_SUBSLEEP);
      wr(IDX_LATCH, 8'h0f);
      tick(2);
      `CHK("subslp", 8'haa, pin_out)
   endtask

   initial
   begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      tick(1);
      t_reset();
      t_io();
      t_func();
      t_irq();
      t_capture();
      t_power();
      stop_test();
   end
endmodule
